/* verilog/fifo_flag_core.sv */
// fifo with pin-side write/read clocks sampled on pclk, flags and apb registers
module fifo_flag_core #(
  parameter int DATA_W = fifo_flag_pkg::DATA_W,
  parameter int DEPTH = fifo_flag_pkg::DEPTH,
  parameter int CNT_W = $clog2(DEPTH + 1),
  parameter int PTR_W = $clog2(DEPTH)
) (
  input wire logic pclk, // system clock
  input wire logic presetn, // async reset, low active
  input wire logic ce, // clock enable, freezes state when low
  input wire logic psel, // apb select
  input wire logic penable, // apb enable
  input wire logic pwrite, // apb direction
  input wire logic [fifo_flag_pkg::ADDR_W-1:0] paddr, // apb byte address
  input wire logic [31:0] pwdata, // apb write data
  output logic [31:0] prdata, // apb read data
  output logic pready, // apb ready
  output logic pslverr, // apb error on unmapped address
  input wire logic wclk, // write clock pin
  input wire logic rclk, // read clock pin
  input wire logic wen1_n, // write enable, low active
  input wire logic second_write_enable_or_load_select, // dual role pin
  input wire logic ren_n, // read enable, low active
  input wire logic oe_n, // output enable, low active
  input wire logic [DATA_W-1:0] wr_data, // data in
  output logic [DATA_W-1:0] rd_data, // data out
  output logic rd_data_oe, // data out drive enable
  output logic full_indicator, // fifo full
  output logic empty_indicator, // fifo empty
  output logic almost_empty_indicator, // fill below almost-empty offset
  output logic almost_full_indicator // fill above depth minus offset
);
  localparam int PIN_W = fifo_flag_pkg::PIN_W;
  localparam int LAT = fifo_flag_pkg::FLAG_LAT_CYC;
  localparam logic [CNT_W-1:0] DEPTH_C = CNT_W'(DEPTH);

  logic [PIN_W-1:0] meta_ff, sync_ff;
  logic wclk_prev_ff, rclk_prev_ff;
  logic [1:0] strap_age_ff;
  logic cfg_done_ff, mode_ff;
  logic [DATA_W-1:0] mem_ff [DEPTH];
  logic [PTR_W-1:0] wptr_ff, rptr_ff;
  logic [CNT_W-1:0] cnt_ff, ae_ofs_ff, af_ofs_ff;
  logic ld_wsel_ff, ld_rsel_ff;
  logic [DATA_W-1:0] q_ff;
  logic q_oe_ff, empty_ff, full_ff, ae_ff, af_ff;
  logic [31:0] prdata_ff;
  logic pready_ff, pslverr_ff;
  logic wr_edge, rd_edge, wen1_s, wen2_s, ren_s, load_sel;
  logic fifo_wr, fifo_rd, ofs_wr, ofs_rd;
  logic apb_setup, apb_wr, flush;
  logic [DATA_W-1:0] d_s;
  logic [31:0] status_word;

  // two-flop synchroniser for every pin input
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      meta_ff <= '0;
      sync_ff <= '0;
    end
    else if (ce)
    begin
      meta_ff <= {wclk, rclk, wen1_n, second_write_enable_or_load_select, ren_n, oe_n, wr_data};
      sync_ff <= meta_ff;
    end
  end

  // edge history reads only the second stage
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wclk_prev_ff <= 1'b0;
      rclk_prev_ff <= 1'b0;
    end
    else if (ce)
    begin
      wclk_prev_ff <= sync_ff[fifo_flag_pkg::PIN_WCLK];
      rclk_prev_ff <= sync_ff[fifo_flag_pkg::PIN_RCLK];
    end
  end

  assign wr_edge = sync_ff[fifo_flag_pkg::PIN_WCLK] & ~wclk_prev_ff;
  assign rd_edge = sync_ff[fifo_flag_pkg::PIN_RCLK] & ~rclk_prev_ff;
  assign wen1_s = ~sync_ff[fifo_flag_pkg::PIN_WEN1];
  assign wen2_s = sync_ff[fifo_flag_pkg::PIN_WEN2];
  assign ren_s = ~sync_ff[fifo_flag_pkg::PIN_REN];
  assign d_s = sync_ff[DATA_W-1:0];

  // strap capture once the synchroniser holds the post-reset pin level
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      strap_age_ff <= 2'h0;
      cfg_done_ff <= 1'b0;
      mode_ff <= 1'b0;
    end
    else if (ce && !cfg_done_ff)
    begin
      strap_age_ff <= strap_age_ff + 2'h1;
      if (strap_age_ff == fifo_flag_pkg::STRAP_AGE)
      begin
        cfg_done_ff <= 1'b1;
        mode_ff <= wen2_s;
      end
    end
  end

  // pin low in load mode steers transfers to the offset registers
  assign load_sel = cfg_done_ff & ~mode_ff & ~wen2_s;
  assign fifo_wr = cfg_done_ff & wr_edge & wen1_s & wen2_s & ~full_ff;
  assign fifo_rd = cfg_done_ff & rd_edge & ren_s & ~load_sel & ~empty_ff;
  assign ofs_wr = wr_edge & wen1_s & load_sel;
  assign ofs_rd = rd_edge & ren_s & load_sel;

  assign apb_setup = psel & ~penable & ~pready_ff;
  assign apb_wr = psel & penable & pready_ff & pwrite;
  assign flush = apb_wr & (paddr == fifo_flag_pkg::CTRL_ADDR) & pwdata[fifo_flag_pkg::CTRL_FLUSH_BIT];

  // storage
  always_ff @(posedge pclk)
  begin
    if (ce && fifo_wr)
      mem_ff[wptr_ff] <= d_s;
  end

  // pointers and fill count; clocks may run through reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      wptr_ff <= '0;
      rptr_ff <= '0;
      cnt_ff <= '0;
    end
    else if (ce)
    begin
      if (flush)
      begin
        wptr_ff <= '0;
        rptr_ff <= '0;
        cnt_ff <= '0;
      end
      else
      begin
        if (fifo_wr)
          wptr_ff <= wptr_ff + PTR_W'(1);
        if (fifo_rd)
          rptr_ff <= rptr_ff + PTR_W'(1);
        cnt_ff <= cnt_ff + CNT_W'(fifo_wr) - CNT_W'(fifo_rd);
      end
    end
  end

  // flags follow the count one cycle later, two cycles after a synced clock edge
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      empty_ff <= 1'b1;
      full_ff <= 1'b0;
      ae_ff <= 1'b1;
      af_ff <= 1'b0;
    end
    else if (ce)
    begin
      empty_ff <= (cnt_ff == '0);
      full_ff <= (cnt_ff == DEPTH_C);
      ae_ff <= (cnt_ff < ae_ofs_ff);
      af_ff <= (cnt_ff > DEPTH_C - af_ofs_ff);
    end
  end

  // offset registers: apb or load-pin sequence, almost-empty first
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      ae_ofs_ff <= CNT_W'(fifo_flag_pkg::AE_OFFSET_RST);
      af_ofs_ff <= CNT_W'(fifo_flag_pkg::AF_OFFSET_RST);
      ld_wsel_ff <= 1'b0;
      ld_rsel_ff <= 1'b0;
    end
    else if (ce)
    begin
      if (ofs_wr)
      begin
        ld_wsel_ff <= ~ld_wsel_ff;
        if (ld_wsel_ff)
          af_ofs_ff <= CNT_W'(d_s);
        else
          ae_ofs_ff <= CNT_W'(d_s);
      end
      else if (apb_wr && paddr == fifo_flag_pkg::AE_OFFSET_ADDR)
        ae_ofs_ff <= pwdata[CNT_W-1:0];
      else if (apb_wr && paddr == fifo_flag_pkg::AF_OFFSET_ADDR)
        af_ofs_ff <= pwdata[CNT_W-1:0];
      if (ofs_rd)
        ld_rsel_ff <= ~ld_rsel_ff;
    end
  end

  // read data register, low after reset
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      q_ff <= '0;
      q_oe_ff <= 1'b0;
    end
    else if (ce)
    begin
      q_oe_ff <= ~sync_ff[fifo_flag_pkg::PIN_OE];
      if (fifo_rd)
        q_ff <= mem_ff[rptr_ff];
      else if (ofs_rd)
        q_ff <= DATA_W'(ld_rsel_ff ? af_ofs_ff : ae_ofs_ff);
    end
  end

  always_comb
  begin
    status_word = '0;
    status_word[fifo_flag_pkg::ST_EMPTY_BIT] = empty_ff;
    status_word[fifo_flag_pkg::ST_FULL_BIT] = full_ff;
    status_word[fifo_flag_pkg::ST_AE_BIT] = ae_ff;
    status_word[fifo_flag_pkg::ST_AF_BIT] = af_ff;
    status_word[fifo_flag_pkg::ST_MODE_BIT] = mode_ff;
    status_word[fifo_flag_pkg::ST_LOAD_BIT] = ~mode_ff & cfg_done_ff;
    status_word[fifo_flag_pkg::ST_COUNT_LSB +: CNT_W] = cnt_ff;
  end

  // apb slave: no wait state, pready in first access cycle, data latched in setup
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata_ff <= fifo_flag_pkg::RDATA_RST;
      pready_ff <= 1'b0;
      pslverr_ff <= 1'b0;
    end
    else if (ce)
    begin
      pready_ff <= apb_setup;
      if (apb_setup)
      begin
        pslverr_ff <= 1'b0;
        prdata_ff <= '0;
        case (paddr)
          fifo_flag_pkg::CTRL_ADDR: prdata_ff <= '0;
          fifo_flag_pkg::STATUS_ADDR: prdata_ff <= status_word;
          fifo_flag_pkg::AE_OFFSET_ADDR: prdata_ff <= 32'(ae_ofs_ff);
          fifo_flag_pkg::AF_OFFSET_ADDR: prdata_ff <= 32'(af_ofs_ff);
          default: pslverr_ff <= 1'b1;
        endcase
      end
      else if (!psel)
        pslverr_ff <= 1'b0;
    end
  end

  assign prdata = prdata_ff;
  assign pready = pready_ff;
  assign pslverr = pslverr_ff;
  assign rd_data = q_ff;
  assign rd_data_oe = q_oe_ff;
  assign full_indicator = full_ff;
  assign empty_indicator = empty_ff;
  assign almost_empty_indicator = ae_ff;
  assign almost_full_indicator = af_ff;

  // checks
  a_full_track: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) |-> full_ff == ($past(cnt_ff) == DEPTH_C))
    else $error("full flag does not follow fill count");

  a_empty_track: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && fifo_wr && cnt_ff == '0 && !fifo_rd) |-> ##LAT (!empty_ff || !ce || $past(flush, LAT)))
    else $error("empty flag not cleared after write");

  a_no_overflow: assert property (@(posedge pclk) disable iff (!presetn)
    cnt_ff <= DEPTH_C)
    else $error("fill count exceeds depth");

  a_no_underflow: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && empty_ff && cnt_ff == '0) |=> cnt_ff <= CNT_W'(1))
    else $error("read from empty fifo");

  a_first_word: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && fifo_rd) |=> q_ff == $past(mem_ff[rptr_ff]))
    else $error("read data not presented next cycle");

  a_ae_level: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) |-> ae_ff == ($past(cnt_ff) < $past(ae_ofs_ff)))
    else $error("almost-empty level wrong");

  a_af_level: assert property (@(posedge pclk) disable iff (!presetn)
    $past(ce) |-> af_ff == ($past(cnt_ff) > DEPTH_C - $past(af_ofs_ff)))
    else $error("almost-full level wrong");

  a_reset_data_low: assert property (@(posedge pclk) disable iff (!presetn)
    !$past(presetn) |-> (q_ff == '0 && empty_ff && !full_ff))
    else $error("outputs not cleared by reset");

  a_mode_frozen: assert property (@(posedge pclk) disable iff (!presetn)
    $past(cfg_done_ff) |-> $stable(mode_ff))
    else $error("pin role changed after strap");

  a_apb_wait: assert property (@(posedge pclk) disable iff (!presetn)
    (ce && apb_setup) |=> pready_ff ##1 (!pready_ff || !$past(ce)))
    else $error("apb ready not one cycle after setup");

  c_fill_full: cover property (@(posedge pclk) disable iff (!presetn) full_ff);
  c_write_then_read: cover property (@(posedge pclk) disable iff (!presetn)
    fifo_wr ##[1:20] fifo_rd);
  c_load_write: cover property (@(posedge pclk) disable iff (!presetn) ofs_wr);
  c_almost_full: cover property (@(posedge pclk) disable iff (!presetn) $rose(af_ff));
endmodule

/* verilog/fifo_flag_pkg.sv */
// constants for the flag-tracking fifo: register map, field layout, timing
package fifo_flag_pkg;
  localparam int DATA_W = 9;
  localparam int DEPTH = 256;
  localparam int ADDR_W = 8;
  // register byte addresses
  localparam logic [7:0] CTRL_ADDR = 8'h00;
  localparam logic [7:0] STATUS_ADDR = 8'h04;
  localparam logic [7:0] AE_OFFSET_ADDR = 8'h08;
  localparam logic [7:0] AF_OFFSET_ADDR = 8'h0c;
  // ctrl fields
  localparam int CTRL_FLUSH_BIT = 0;
  // status fields
  localparam int ST_EMPTY_BIT = 0;
  localparam int ST_FULL_BIT = 1;
  localparam int ST_AE_BIT = 2;
  localparam int ST_AF_BIT = 3;
  localparam int ST_MODE_BIT = 4;
  localparam int ST_LOAD_BIT = 5;
  localparam int ST_COUNT_LSB = 8;
  // reset values
  localparam int AE_OFFSET_RST = 7;
  localparam int AF_OFFSET_RST = 7;
  localparam logic [31:0] RDATA_RST = 32'h0000_0000;
  // pin vector layout: {wclk, rclk, wen1_n, second_write_enable_or_load_select, ren_n, oe_n, data}
  localparam int PIN_WCLK = DATA_W + 5;
  localparam int PIN_RCLK = DATA_W + 4;
  localparam int PIN_WEN1 = DATA_W + 3;
  localparam int PIN_WEN2 = DATA_W + 2;
  localparam int PIN_REN = DATA_W + 1;
  localparam int PIN_OE = DATA_W;
  localparam int PIN_W = DATA_W + 6;
  // strap sampled once the pin synchroniser is filled
  localparam logic [1:0] STRAP_AGE = 2'h2;
  // timing
  localparam int CLK_PERIOD_NS = 10;
  localparam int FLAG_SKEW_NS = 6;
  localparam int PARTIAL_SKEW_NS = 15;
  localparam int FLAG_SKEW_CYC = (FLAG_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int PARTIAL_SKEW_CYC = (PARTIAL_SKEW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  // flag update latency from a synced clock edge, in pclk cycles
  localparam int FLAG_LAT_CYC = 2;
endpackage

/* tb/fifo_pin_agent.sv */
// pin-side writer and reader, each on its own slow clock
module fifo_pin_agent
(
  input wire logic pclk, // system clock
  output logic wclk, // write clock pin
  output logic rclk, // read clock pin
  output logic wen1_n, // write enable, low active
  output logic dual_pin, // strap, then second enable or load select
  output logic ren_n, // read enable, low active
  output logic [fifo_flag_pkg::DATA_W-1:0] wr_data // data in
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    wclk = 1'b0;
    rclk = 1'b0;
    wen1_n = 1'b1;
    ren_n = 1'b1;
    dual_pin = 1'b1;
    wr_data = '0;
  end
  // strap level held across reset and after it
  task automatic strap(input logic v);
    dual_pin <= v;
  endtask
  // both clocks toggle with enables idle
  task automatic spin(input int n);
    repeat (n)
    begin
      repeat (2) @(posedge pclk);
      wclk <= ~wclk;
      rclk <= ~rclk;
    end
  endtask
  // one write or read: 3 pclk low, 3 high, 4 low
  task automatic xfer(input bit wr, input logic [fifo_flag_pkg::DATA_W-1:0] d);
    @(posedge pclk);
    if (wr)
    begin
      wr_data <= d;
      wen1_n <= 1'b0;
    end
    else
      ren_n <= 1'b0;
    repeat (3) @(posedge pclk);
    if (wr)
      wclk <= 1'b1;
    else
      rclk <= 1'b1;
    repeat (3) @(posedge pclk);
    wclk <= 1'b0;
    rclk <= 1'b0;
    wen1_n <= 1'b1;
    ren_n <= 1'b1;
    // no stale word after hold
    wr_data <= ~d;
    repeat (4) @(posedge pclk);
  endtask
endmodule

/* tb/dual_clock_fifo_flag_reset_timing_test.sv */
// self-checking bench for the flag-tracking fifo
module dual_clock_fifo_flag_reset_timing_test;
  timeunit 1ns;
  timeprecision 1ps;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, oe_n, last_err;
  logic wclk, rclk, wen1_n, dual_pin, ren_n, rd_data_oe;
  logic full_indicator, empty_indicator, almost_empty_indicator, almost_full_indicator;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rv;
  logic [8:0] wr_data, rd_data;
  int n_errors, samples_checked;

  fifo_pin_agent fifo_pin_agent_i (.pclk(pclk), .wclk(wclk), .rclk(rclk), .wen1_n(wen1_n),
    .dual_pin(dual_pin), .ren_n(ren_n), .wr_data(wr_data));
  fifo_flag_core fifo_flag_core_i (.pclk(pclk), .presetn(presetn), .ce(1'b1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .wclk(wclk), .rclk(rclk), .wen1_n(wen1_n),
    .second_write_enable_or_load_select(dual_pin), .ren_n(ren_n), .oe_n(oe_n),
    .wr_data(wr_data), .rd_data(rd_data), .rd_data_oe(rd_data_oe),
    .full_indicator(full_indicator), .empty_indicator(empty_indicator),
    .almost_empty_indicator(almost_empty_indicator),
    .almost_full_indicator(almost_full_indicator));

  initial
  begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic tally_and_finish();
    $display("mismatches %0d comparisons %0d", n_errors, samples_checked);
    if (n_errors == 0 && samples_checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, got);
    end
  endtask

  // order: full, empty, almost empty, almost full
  task automatic chk_flags(input logic [3:0] exp);
    logic [3:0] got;
    got = {full_indicator, empty_indicator, almost_empty_indicator, almost_full_indicator};
    samples_checked++;
    if (got !== exp)
    begin
      n_errors++;
      $display("BAD flags expected %b seen %b", exp, got);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do
    begin
      @(posedge pclk);
      i++;
    end
    while (pready !== 1'b1 && i < 16);
    rv = prdata;
    last_err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1)
    begin
      n_errors++;
      tally_and_finish();
    end
  endtask

  task automatic do_reset(input logic mode);
    @(posedge pclk);
    fifo_pin_agent_i.strap(mode);
    presetn <= 1'b0;
    fifo_pin_agent_i.spin(4);
    presetn <= 1'b1;
    repeat (8) @(posedge pclk);
  endtask

  initial
  begin
    repeat (100000) @(posedge pclk);
    n_errors++;
    tally_and_finish();
  end

  initial
  begin
    n_errors = 0;
    samples_checked = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 8'h00;
    pwdata = 32'h0;
    oe_n = 1'b1;
    do_reset(1'b1);
    chk_flags(4'b0110);
    chk("outputs", 32'h0, {22'h0, rd_data_oe, rd_data});
    oe_n <= 1'b0;
    repeat (4) @(posedge pclk);
    chk("outputs", 32'h200, {22'h0, rd_data_oe, rd_data});
    apb(1'b0, fifo_flag_pkg::STATUS_ADDR, 32'h0);
    chk("status", 32'h15, rv);
    apb(1'b0, fifo_flag_pkg::AE_OFFSET_ADDR, 32'h0);
    chk("ae offset", 32'h7, rv);
    apb(1'b1, fifo_flag_pkg::AF_OFFSET_ADDR, 32'h3);
    apb(1'b0, fifo_flag_pkg::AF_OFFSET_ADDR, 32'h0);
    chk("af offset", 32'h3, rv);
    apb(1'b0, 8'h10, 32'h0);
    chk("slverr", 32'h1, {31'h0, last_err});
    fifo_pin_agent_i.xfer(1'b0, 9'h000);
    chk("outputs", 32'h200, {22'h0, rd_data_oe, rd_data});
    fifo_pin_agent_i.xfer(1'b1, 9'h1a5);
    chk_flags(4'b0010);
    fifo_pin_agent_i.xfer(1'b0, 9'h000);
    chk("outputs", 32'h3a5, {22'h0, rd_data_oe, rd_data});
    chk_flags(4'b0110);
    for (int i = 1; i <= 7; i++)
    begin
      fifo_pin_agent_i.xfer(1'b1, 9'(i));
      chk_flags({2'b00, (i < 7), 1'b0});
    end
    fifo_pin_agent_i.xfer(1'b0, 9'h000);
    chk_flags(4'b0010);
    chk("outputs", 32'h201, {22'h0, rd_data_oe, rd_data});
    for (int j = 7; j <= 256; j++)
    begin
      fifo_pin_agent_i.xfer(1'b1, 9'(j));
      chk_flags({(j == 256), 2'b00, (j >= 254)});
    end
    fifo_pin_agent_i.xfer(1'b1, 9'h0ff);
    apb(1'b0, fifo_flag_pkg::STATUS_ADDR, 32'h0);
    chk("status", 32'h0001_001a, rv);
    fifo_pin_agent_i.xfer(1'b0, 9'h000);
    chk_flags(4'b0001);
    chk("outputs", 32'h202, {22'h0, rd_data_oe, rd_data});
    apb(1'b1, fifo_flag_pkg::CTRL_ADDR, 32'h1);
    apb(1'b0, fifo_flag_pkg::STATUS_ADDR, 32'h0);
    chk("status", 32'h15, rv);
    // second enable low in two-enable mode blocks pin writes
    fifo_pin_agent_i.strap(1'b0);
    fifo_pin_agent_i.xfer(1'b1, 9'h0aa);
    chk_flags(4'b0110);
    do_reset(1'b0);
    apb(1'b0, fifo_flag_pkg::STATUS_ADDR, 32'h0);
    chk("status", 32'h25, rv);
    apb(1'b0, fifo_flag_pkg::AF_OFFSET_ADDR, 32'h0);
    chk("af offset", 32'h7, rv);
    // load mode: pin writes fill n then m, pin read returns n
    fifo_pin_agent_i.xfer(1'b1, 9'h005);
    fifo_pin_agent_i.xfer(1'b1, 9'h009);
    apb(1'b0, fifo_flag_pkg::AE_OFFSET_ADDR, 32'h0);
    chk("ae offset", 32'h5, rv);
    apb(1'b0, fifo_flag_pkg::AF_OFFSET_ADDR, 32'h0);
    chk("af offset", 32'h9, rv);
    fifo_pin_agent_i.xfer(1'b0, 9'h000);
    chk("outputs", 32'h205, {22'h0, rd_data_oe, rd_data});
    apb(1'b0, fifo_flag_pkg::STATUS_ADDR, 32'h0);
    chk("status", 32'h25, rv);
    tally_and_finish();
  end
endmodule
